// >>> logic/gpsel_params.svh
// Purpose: offsets, field positions and reset values of the pin selector
// Assumes: 8-bit register port, byte addressed
// Notes:   definitions only
`ifndef GPSEL_PARAMS_SVH
`define GPSEL_PARAMS_SVH
`define GPSEL_ADDR_W        8
`define GPSEL_OFS_PIN5_CTL  8'h15
`define GPSEL_OFS_PIN0_VAL  8'h20
`define GPSEL_OFS_STATUS    8'h21
`define GPSEL_CTL_RESET     8'h00
`define GPSEL_PIN0_RESET    8'h00
`define GPSEL_BIT_EN        0
`define GPSEL_BIT_VAL       1
`define GPSEL_SRC_LSB       2
`define GPSEL_SRC_MSB       4
`define GPSEL_SEL_LSB       5
`define GPSEL_SEL_MSB       7
`endif

// >>> logic/gpsel_pkg.sv
// Purpose: types of the pin selector
// Assumes: nothing
// Notes:   code values fixed by the control register layout
package gpsel_pkg;
  typedef enum logic [2:0]
  {
    GPSEL_SRC_RX0  = 3'h0,
    GPSEL_SRC_RX1  = 3'h1,
    GPSEL_SRC_RX2  = 3'h2,
    GPSEL_SRC_RX3  = 3'h3,
    GPSEL_SRC_DEV  = 3'h4,
    GPSEL_SRC_RSVD = 3'h5,
    GPSEL_SRC_TX0  = 3'h6,
    GPSEL_SRC_TX1  = 3'h7
  } gpsel_src_e;
  typedef logic [2:0] gpsel_sel_t;
endpackage

// >>> logic/gpsel_ctl_if.sv
// Purpose: carries control fields from register file to the selector
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface gpsel_ctl_if;
  import gpsel_pkg::*;
  gpsel_src_e src;
  gpsel_sel_t sel;
  logic       out_val;
  logic       pin0_val;
  modport regs (output src, output sel, output out_val, output pin0_val);
  modport mux  (input src, input sel, input out_val, input pin0_val);
endinterface
`default_nettype wire

// >>> logic/gpsel_mux.sv
// Purpose: combinational signal selection for one pin
// Assumes: all inputs already synchronised
// Notes:   reserved codes give 0
`timescale 1ns/10ps
`default_nettype none
module gpsel_mux
  import gpsel_pkg::*;
(
  gpsel_ctl_if.mux          ctl,
  input  wire logic [15:0]  i_rx_gpio,
  input  wire logic [3:0]   i_rx_lock,
  input  wire logic [3:0]   i_rx_pass,
  input  wire logic [3:0]   i_rx_fv,
  input  wire logic [3:0]   i_rx_lv,
  input  wire logic [3:0]   i_rx_en,
  input  wire logic         i_frame_sync_signal,
  input  wire logic [1:0]   i_tx_pass_and,
  input  wire logic [1:0]   i_tx_pass_or,
  input  wire logic [1:0]   i_tx_fv,
  input  wire logic [1:0]   i_tx_lv,
  input  wire logic [1:0]   i_tx_sync,
  input  wire logic [1:0]   i_tx_irq,
  output logic              o_sel
);
  wire logic [1:0] rx_idx = ctl.src[1:0];
  wire logic       tx_idx = ctl.src[0];
  wire logic [7:0] rx_vec = {i_rx_lv[rx_idx], i_rx_fv[rx_idx],
                             i_rx_pass[rx_idx], i_rx_lock[rx_idx],
                             i_rx_gpio[{rx_idx, 2'h3}],
                             i_rx_gpio[{rx_idx, 2'h2}],
                             i_rx_gpio[{rx_idx, 2'h1}],
                             i_rx_gpio[{rx_idx, 2'h0}]};
  // disabled ports drop out: OR ignores them, AND treats them as passing
  wire logic       any_lock = |(i_rx_lock & i_rx_en);
  wire logic       all_pass = &(i_rx_pass | ~i_rx_en);
  wire logic [7:0] dev_vec = {3'h0, i_frame_sync_signal, 1'h0, all_pass,
                              any_lock, ctl.pin0_val};
  wire logic [7:0] tx_vec = {2'h0, i_tx_irq[tx_idx], i_tx_sync[tx_idx],
                             i_tx_lv[tx_idx], i_tx_fv[tx_idx],
                             i_tx_pass_or[tx_idx],
                             i_tx_pass_and[tx_idx]};
  always_comb
  begin
    case (ctl.src)
      GPSEL_SRC_RX0, GPSEL_SRC_RX1, GPSEL_SRC_RX2, GPSEL_SRC_RX3:
        o_sel = rx_vec[ctl.sel];
      GPSEL_SRC_DEV:
        o_sel = dev_vec[ctl.sel];
      GPSEL_SRC_TX0, GPSEL_SRC_TX1:
        o_sel = tx_vec[ctl.sel];
      default:
        o_sel = 1'h0;
    endcase
  end
endmodule
`default_nettype wire

// >>> logic/gpsel_regs.sv
// Purpose: control register file of the pin selector
// Assumes: one-cycle strobes, never both at once
// Notes:   read data valid only the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "gpsel_params.svh"
module gpsel_regs
  import gpsel_pkg::*;
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic [`GPSEL_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic                     i_pin_level,
  gpsel_ctl_if.regs                     ctl,
  output logic [7:0]                    o_ctl,
  output logic [7:0]                    o_rdata
);
  logic [7:0] ctl_q;
  logic       pin0_q;
  logic [7:0] rdata_q;
  wire logic  hit_ctl  = i_addr == `GPSEL_OFS_PIN5_CTL;
  wire logic  hit_pin0 = i_addr == `GPSEL_OFS_PIN0_VAL;
  wire logic  hit_stat = i_addr == `GPSEL_OFS_STATUS;
  // unmapped addresses read zero and ignore writes
  wire logic [7:0] rd_mux = hit_ctl  ? ctl_q :
                            hit_pin0 ? {7'h00, pin0_q} :
                            hit_stat ? {7'h00, i_pin_level} : 8'h00;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctl_q   <= `GPSEL_CTL_RESET;
      pin0_q  <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (i_wr && hit_ctl)
        ctl_q <= i_wdata;
      if (i_wr && hit_pin0)
        pin0_q <= i_wdata[0];
      rdata_q <= i_rd ? rd_mux : 8'h00;
    end
  end
  assign ctl.src      = gpsel_src_e'(ctl_q[`GPSEL_SRC_MSB:`GPSEL_SRC_LSB]);
  assign ctl.sel      = ctl_q[`GPSEL_SEL_MSB:`GPSEL_SEL_LSB];
  assign ctl.out_val  = ctl_q[`GPSEL_BIT_VAL];
  assign ctl.pin0_val = pin0_q;
  assign o_ctl        = ctl_q;
  assign o_rdata      = rdata_q;
endmodule
`default_nettype wire

// >>> logic/gpsel_top.sv
// Purpose: output selector for general-purpose pin 5
// Assumes: source signals come from other domains and are synchronised here
// Notes:   pin value is registered, three cycles behind the source inputs (two synchroniser flops, one output flop)
//
// Contract
// - source field bits 4:2 picks rx port 0-3, device status, or tx 0/1.
// - rx source with select 0-3 forwards that port's remote gpio 0-3.
// - rx source with select 4/5 outputs the port's lock/pass.
// - rx source with select 6/7 outputs the port's frame/line valid.
// - device source with select 0 outputs the pin0 local value bit.
// - device source with select 1 outputs OR of lock of enabled ports.
// - device source with select 2 outputs AND of pass of enabled ports.
// - device source with select 4 outputs frame sync; 5-7 reserved.
// - tx source with select 0/1 outputs AND/OR of selected rx status.
// - tx source with select 2/3 outputs frame/line being sent.
// - tx source with select 4/5 outputs synchronised/interrupt.
// - bit 1 holds the local output value.
// - bit 0 enables the pin driver.
// - the control register at 0x15 resets to 0x00.
`timescale 1ns/10ps
`default_nettype none
`include "gpsel_params.svh"
module gpsel_top
  import gpsel_pkg::*;
#(
  parameter int SYNC_W = 49
)
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic [`GPSEL_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic [7:0]                    o_rdata,
  input  wire logic [15:0]              i_rx_gpio,
  input  wire logic [3:0]               i_rx_lock,
  input  wire logic [3:0]               i_rx_pass,
  input  wire logic [3:0]               i_rx_fv,
  input  wire logic [3:0]               i_rx_lv,
  input  wire logic [3:0]               i_rx_en,
  input  wire logic                     i_frame_sync_signal,
  input  wire logic [1:0]               i_tx_pass_and,
  input  wire logic [1:0]               i_tx_pass_or,
  input  wire logic [1:0]               i_tx_fv,
  input  wire logic [1:0]               i_tx_lv,
  input  wire logic [1:0]               i_tx_sync,
  input  wire logic [1:0]               i_tx_irq,
  output logic                          o_pin5_out,
  output logic                          o_pin5_oe
);
  if (SYNC_W != 49)
  begin : g_bad_sync_w
    $error("SYNC_W must equal the number of source inputs");
  end

  gpsel_ctl_if ctl ();

  logic [7:0]        ctl_q;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic              pin_q;
  logic              oe_q;
  logic              sel;

  // async sources pass two flops; vector is sliced back out below
  wire logic [SYNC_W-1:0] raw = {i_rx_gpio, i_rx_lock, i_rx_pass, i_rx_fv,
                                 i_rx_lv, i_rx_en, i_frame_sync_signal,
                                 i_tx_pass_and, i_tx_pass_or, i_tx_fv,
                                 i_tx_lv, i_tx_sync, i_tx_irq};
  wire logic [15:0] s_rx_gpio = sync_q[48:33];
  wire logic [3:0]  s_rx_lock = sync_q[32:29];
  wire logic [3:0]  s_rx_pass = sync_q[28:25];
  wire logic [3:0]  s_rx_fv   = sync_q[24:21];
  wire logic [3:0]  s_rx_lv   = sync_q[20:17];
  wire logic [3:0]  s_rx_en   = sync_q[16:13];
  wire logic        s_fsync   = sync_q[12];
  wire logic [1:0]  s_tx_pand = sync_q[11:10];
  wire logic [1:0]  s_tx_por  = sync_q[9:8];
  wire logic [1:0]  s_tx_fv   = sync_q[7:6];
  wire logic [1:0]  s_tx_lv   = sync_q[5:4];
  wire logic [1:0]  s_tx_sync = sync_q[3:2];
  wire logic [1:0]  s_tx_irq  = sync_q[1:0];
  wire logic        en        = ctl_q[`GPSEL_BIT_EN];

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  gpsel_regs u_regs
  (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_addr      (i_addr),
    .i_wdata     (i_wdata),
    .i_wr        (i_wr),
    .i_rd        (i_rd),
    .i_pin_level (pin_q),
    .ctl         (ctl.regs),
    .o_ctl       (ctl_q),
    .o_rdata     (o_rdata)
  );

  gpsel_mux u_mux
  (
    .ctl                 (ctl.mux),
    .i_rx_gpio           (s_rx_gpio),
    .i_rx_lock           (s_rx_lock),
    .i_rx_pass           (s_rx_pass),
    .i_rx_fv             (s_rx_fv),
    .i_rx_lv             (s_rx_lv),
    .i_rx_en             (s_rx_en),
    .i_frame_sync_signal (s_fsync),
    .i_tx_pass_and       (s_tx_pand),
    .i_tx_pass_or        (s_tx_por),
    .i_tx_fv             (s_tx_fv),
    .i_tx_lv             (s_tx_lv),
    .i_tx_sync           (s_tx_sync),
    .i_tx_irq            (s_tx_irq),
    .o_sel               (sel)
  );

  // data forced low while disabled so nothing leaks when re-enabled
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      oe_q  <= en;
      pin_q <= en & sel;
    end
  end

  assign o_pin5_out = pin_q;
  assign o_pin5_oe  = oe_q;

  sequence s_enable_write;
    i_wr && i_addr == `GPSEL_OFS_PIN5_CTL && i_wdata[0];
  endsequence

  property p_oe_follows;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_enable_write |-> ##2 o_pin5_oe;
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("output enable did not follow write");

  property p_no_drive_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !o_pin5_oe |-> !o_pin5_out;
  endproperty
  a_no_drive_off: assert property (p_no_drive_off)
    else $error("pin data while disabled");

  property p_reset_val;
    @(posedge i_mclk) $rose(i_rst_n) |-> ctl_q == `GPSEL_CTL_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("control not reset to zero");

  property p_rsvd_src;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ctl_q[4:2] == 3'h5 && en |=> !o_pin5_out;
  endproperty
  a_rsvd_src: assert property (p_rsvd_src)
    else $error("reserved source drove pin");

  property p_rx_gpio;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h0 && ctl_q[7:5] == 3'h2
      |=> o_pin5_out == $past(s_rx_gpio[2]);
  endproperty
  a_rx_gpio: assert property (p_rx_gpio)
    else $error("rx gpio not forwarded");

  property p_rx_lock;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h3 && ctl_q[7:5] == 3'h4
      |=> o_pin5_out == $past(s_rx_lock[3]);
  endproperty
  a_rx_lock: assert property (p_rx_lock)
    else $error("rx lock not forwarded");

  property p_rx_lv;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h1 && ctl_q[7:5] == 3'h7
      |=> o_pin5_out == $past(s_rx_lv[1]);
  endproperty
  a_rx_lv: assert property (p_rx_lv)
    else $error("rx line valid not forwarded");

  property p_dev_lock;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h4 && ctl_q[7:5] == 3'h1
      |=> o_pin5_out == $past(|(s_rx_lock & s_rx_en));
  endproperty
  a_dev_lock: assert property (p_dev_lock)
    else $error("lock OR wrong");

  property p_dev_pass;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h4 && ctl_q[7:5] == 3'h2
      |=> o_pin5_out == $past(&(s_rx_pass | ~s_rx_en));
  endproperty
  a_dev_pass: assert property (p_dev_pass)
    else $error("pass AND wrong");

  property p_tx_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h7 && ctl_q[7:5] == 3'h5
      |=> o_pin5_out == $past(s_tx_irq[1]);
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("tx interrupt not forwarded");

  property p_local_val;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h4 && ctl_q[7:5] == 3'h0
      |=> o_pin5_out == $past(ctl.pin0_val);
  endproperty
  a_local_val: assert property (p_local_val)
    else $error("pin0 value not output");

  sequence s_disable_write;
    i_wr && i_addr == `GPSEL_OFS_PIN5_CTL && !i_wdata[0];
  endsequence

  sequence s_ctl_write;
    i_wr && i_addr == `GPSEL_OFS_PIN5_CTL;
  endsequence

  property p_oe_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_disable_write |-> ##2 !o_pin5_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output enable did not drop after write");

  property p_val_bit;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_ctl_write |=> ctl_q[`GPSEL_BIT_VAL] == $past(i_wdata[1]);
  endproperty
  a_val_bit: assert property (p_val_bit)
    else $error("value bit not stored");

  property p_rx_pass;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h2 && ctl_q[7:5] == 3'h5
      |=> o_pin5_out == $past(s_rx_pass[2]);
  endproperty
  a_rx_pass: assert property (p_rx_pass)
    else $error("rx pass not forwarded");

  property p_rx_fv;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h0 && ctl_q[7:5] == 3'h6
      |=> o_pin5_out == $past(s_rx_fv[0]);
  endproperty
  a_rx_fv: assert property (p_rx_fv)
    else $error("rx frame valid not forwarded");

  property p_rx_gpio3;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h3 && ctl_q[7:5] == 3'h3
      |=> o_pin5_out == $past(s_rx_gpio[15]);
  endproperty
  a_rx_gpio3: assert property (p_rx_gpio3)
    else $error("rx port 3 gpio 3 not forwarded");

  property p_dev_fsync;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h4 && ctl_q[7:5] == 3'h4
      |=> o_pin5_out == $past(s_fsync);
  endproperty
  a_dev_fsync: assert property (p_dev_fsync)
    else $error("frame sync not forwarded");

  property p_dev_rsvd;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h4 && ctl_q[7:5] >= 3'h5
      |=> !o_pin5_out;
  endproperty
  a_dev_rsvd: assert property (p_dev_rsvd)
    else $error("reserved device select drove pin");

  property p_tx_and;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h6 && ctl_q[7:5] == 3'h0
      |=> o_pin5_out == $past(s_tx_pand[0]);
  endproperty
  a_tx_and: assert property (p_tx_and)
    else $error("tx pass AND not forwarded");

  property p_tx_or;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h7 && ctl_q[7:5] == 3'h1
      |=> o_pin5_out == $past(s_tx_por[1]);
  endproperty
  a_tx_or: assert property (p_tx_or)
    else $error("tx pass OR not forwarded");

  property p_tx_fv;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h6 && ctl_q[7:5] == 3'h2
      |=> o_pin5_out == $past(s_tx_fv[0]);
  endproperty
  a_tx_fv: assert property (p_tx_fv)
    else $error("tx frame not forwarded");

  property p_tx_lv;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h7 && ctl_q[7:5] == 3'h3
      |=> o_pin5_out == $past(s_tx_lv[1]);
  endproperty
  a_tx_lv: assert property (p_tx_lv)
    else $error("tx line not forwarded");

  property p_tx_sync;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:2] == 3'h6 && ctl_q[7:5] == 3'h4
      |=> o_pin5_out == $past(s_tx_sync[0]);
  endproperty
  a_tx_sync: assert property (p_tx_sync)
    else $error("tx synchronised not forwarded");

  property p_tx_rsvd;
    @(posedge i_mclk) disable iff (!i_rst_n)
    en && ctl_q[4:3] == 2'h3 && ctl_q[7:6] == 2'h3
      |=> !o_pin5_out;
  endproperty
  a_tx_rsvd: assert property (p_tx_rsvd)
    else $error("reserved tx select drove pin");
endmodule
`default_nettype wire

// >>> verif/gpsel_pin_load.sv
// Purpose: external load on pin 5, resolves the level seen on the wire
// Assumes: no pull resistor on the net
// Notes:   a released net shows the inverse of the last driven level
`timescale 1ns/10ps
`default_nettype none
module gpsel_pin_load
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_drive,
  input  wire logic i_oe,
  output logic      o_level
);
  logic last_q;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      last_q <= 1'h0;
    else if (i_oe)
      last_q <= i_drive;
  end
  // floating net: never let a stale level pass for a driven one
  assign o_level = i_oe ? i_drive : ~last_q;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench of the pin 5 output selector
// Assumes: inputs held steady long enough to cross the synchronisers
// Notes:   every src/sel code pair is applied with the driver enabled
`timescale 1ns/10ps
`default_nettype none
`include "gpsel_params.svh"
module tb_top;
  import gpsel_pkg::*;
  logic        i_mclk, i_rst_n, i_wr, i_rd, i_frame_sync_signal;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic [15:0] i_rx_gpio;
  logic [3:0]  i_rx_lock, i_rx_pass, i_rx_fv, i_rx_lv, i_rx_en;
  logic [1:0]  i_tx_pass_and, i_tx_pass_or, i_tx_fv, i_tx_lv;
  logic [1:0]  i_tx_sync, i_tx_irq;
  logic        o_pin5_out, o_pin5_oe, pin_level;
  integer      seed = 15810;
  int          failures = 0;
  int          tests_run = 0;
  int          pin0v;
  gpsel_top i_gpsel_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rx_gpio(i_rx_gpio), .i_rx_lock(i_rx_lock),
    .i_rx_pass(i_rx_pass), .i_rx_fv(i_rx_fv), .i_rx_lv(i_rx_lv),
    .i_rx_en(i_rx_en), .i_frame_sync_signal(i_frame_sync_signal),
    .i_tx_pass_and(i_tx_pass_and), .i_tx_pass_or(i_tx_pass_or),
    .i_tx_fv(i_tx_fv), .i_tx_lv(i_tx_lv), .i_tx_sync(i_tx_sync),
    .i_tx_irq(i_tx_irq), .o_pin5_out(o_pin5_out), .o_pin5_oe(o_pin5_oe));
  gpsel_pin_load i_gpsel_pin_load (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_drive(o_pin5_out), .i_oe(o_pin5_oe), .o_level(pin_level));
  initial
  begin
    i_mclk = 1'h0;
    forever #50 i_mclk = ~i_mclk;
  end
  // reference model of the pin, reserved codes give 0
  function automatic int exp_pin(input int c);
    int src;
    int sel;
    int t;
    src = (c >> 2) & 7;
    sel = (c >> 5) & 7;
    t = src & 1;
    if ((c & 1) == 0)
      return 0;
    if (src < 4)
    begin
      if (sel < 4)
        return int'(i_rx_gpio[4*src+sel]);
      case (sel)
        4: return int'(i_rx_lock[src]);
        5: return int'(i_rx_pass[src]);
        6: return int'(i_rx_fv[src]);
        default: return int'(i_rx_lv[src]);
      endcase
    end
    if (src == 4)
    begin
      case (sel)
        0: return pin0v;
        1: return int'((i_rx_lock & i_rx_en) != 4'h0);
        2: return int'((i_rx_pass | ~i_rx_en) == 4'hF);
        4: return int'(i_frame_sync_signal);
        default: return 0;
      endcase
    end
    if (src == 5)
      return 0;
    case (sel)
      0: return int'(i_tx_pass_and[t]);
      1: return int'(i_tx_pass_or[t]);
      2: return int'(i_tx_fv[t]);
      3: return int'(i_tx_lv[t]);
      4: return int'(i_tx_sync[t]);
      5: return int'(i_tx_irq[t]);
      default: return 0;
    endcase
  endfunction
  task automatic chk_reg(input string w, input logic [7:0] g,
                         input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic chk_pin(input string w, input logic g, input logic e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'h1;
    @(posedge i_mclk);
    i_wr    <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'h1;
    @(posedge i_mclk);
    i_rd   <= 1'h0;
    #1 d = o_rdata;
  endtask
  task automatic rnd_in;
    i_rx_gpio           <= 16'($random(seed));
    {i_rx_lock, i_rx_pass, i_rx_fv, i_rx_lv} <= 16'($random(seed));
    i_rx_en             <= 4'($random(seed));
    i_frame_sync_signal <= 1'($random(seed));
    {i_tx_pass_and, i_tx_pass_or, i_tx_fv} <= 6'($random(seed));
    {i_tx_lv, i_tx_sync, i_tx_irq} <= 6'($random(seed));
  endtask
  task automatic end_sim;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #500000;
    failures++;
    end_sim();
  end
  initial
  begin : main
    logic [7:0] d;
    int         c;
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = 18'h0;
    {i_rx_gpio, i_rx_lock, i_rx_pass, i_rx_fv, i_rx_lv, i_rx_en} = 36'h0;
    {i_frame_sync_signal, i_tx_pass_and, i_tx_pass_or} = 5'h0;
    {i_tx_fv, i_tx_lv, i_tx_sync, i_tx_irq} = 8'h0;
    pin0v = 0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    rd(`GPSEL_OFS_PIN5_CTL, d);
    chk_reg("ctl reset", d, 8'h00);
    chk_pin("oe reset", o_pin5_oe, 1'h0);
    // last 32 passes repeat codes with the driver off
    for (int i = 0; i < 160; i++)
    begin
      c = ((i % 64) << 2) | (($random(seed) & 1) << 1) | int'(i < 128);
      pin0v = $random(seed) & 1;
      wr(`GPSEL_OFS_PIN0_VAL, 8'(pin0v));
      wr(`GPSEL_OFS_PIN5_CTL, 8'(c));
      rnd_in();
      repeat (4) @(posedge i_mclk);
      #1;
      chk_pin("pin", o_pin5_out, 1'(exp_pin(c)));
      chk_pin("pin", o_pin5_out, 1'(exp_pin(c)));
      chk_pin("pin", o_pin5_out, 1'(exp_pin(c)));
      chk_pin("oe", o_pin5_oe, 1'(c & 1));
      if (o_pin5_oe === 1'h1)
        chk_pin("wire", pin_level, 1'(exp_pin(c)));
      rd(`GPSEL_OFS_PIN5_CTL, d);
      chk_reg("ctl readback", d, 8'(c));
      rd(`GPSEL_OFS_PIN0_VAL, d);
      chk_reg("pin0 readback", d, 8'(pin0v));
      rd(`GPSEL_OFS_STATUS, d);
      chk_reg("pin level", d, 8'(exp_pin(c)));
    end
    // unmapped place: write is dropped, read gives 0
    wr(8'h3C, 8'hFF);
    rd(8'h3C, d);
    chk_reg("unmapped", d, 8'h00);
    rd(`GPSEL_OFS_PIN5_CTL, d);
    chk_reg("ctl kept", d, 8'(c));
    // drive the pin high first so the reset has something to clear
    wr(`GPSEL_OFS_PIN0_VAL, 8'h01);
    wr(`GPSEL_OFS_PIN5_CTL, 8'h11);
    repeat (2) @(posedge i_mclk);
    #1;
    chk_pin("oe on", o_pin5_oe, 1'h1);
    chk_pin("pin on", o_pin5_out, 1'h1);
    @(posedge i_mclk);
    i_rst_n <= 1'h0;
    @(posedge i_mclk);
    #1;
    chk_pin("oe mid reset", o_pin5_oe, 1'h0);
    chk_pin("pin mid reset", o_pin5_out, 1'h0);
    @(posedge i_mclk);
    i_rst_n <= 1'h1;
    rd(`GPSEL_OFS_PIN5_CTL, d);
    chk_reg("ctl after reset", d, 8'h00);
    rd(`GPSEL_OFS_PIN0_VAL, d);
    chk_reg("pin0 after reset", d, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
